// ### lthp_top.v
// APB control register and indirect host port of the pixel lookup table
// How it works
// - Location field addresses table for reads, writes
// - Bank field picks host and pixel bank
// - Mode 0: value field reads table, read-only
// - Mode 1: value field is plain holding register
// - Lane field picks host-accessed table lane
// - Strobe with mode 1 copies value into table
// - Strobe with mode 0 changes nothing
// - Enable bit gates all host table access
// - Value field sits in low eight bits
// - Insert bit bypasses or inserts table in path
//
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/1ps
`include "lthp_map.vh"
module lthp_top #(
  parameter LANES = 4
) (
  input wire CLK, // 50 MHz clock
  input wire ARST_N, // Asynchronous reset, active low
  input wire PSEL, // APB select
  input wire PENABLE, // APB access phase
  input wire PWRITE, // APB direction
  input wire [11:0] PADDR, // APB byte address
  input wire [31:0] PWDATA, // APB write data
  output reg [31:0] PRDATA, // APB read data
  output reg PREADY, // APB ready
  output reg PSLVERR, // APB error
  input wire [LANES*8-1:0] PIX_IN, // Incoming camera pixels per lane
  input wire PIX_IN_VALID, // Pixel valid
  output reg [LANES*8-1:0] PIX_OUT, // Outgoing pixels per lane
  output reg PIX_OUT_VALID // Outgoing valid
);
  reg [7:0] value_ff;
  reg insert_ff;
  reg [7:0] index_ff;
  reg [1:0] bank_ff;
  reg mode_ff;
  reg [1:0] lane_ff;
  reg enable_ff;
  reg commit_ff;
  wire [7:0] host_rdata;
  wire [LANES*8-1:0] pix_value;
  wire setup;
  wire hit;
  wire wr_go;

  reg [7:0] value_view;
  reg [31:0] ctrl_view;
  wire [7:0] wr_value;
  wire wr_insert;
  wire [7:0] wr_index;
  wire [1:0] wr_bank;
  wire wr_mode;
  wire [1:0] wr_lane;
  wire wr_commit;
  wire wr_enable;
  reg [7:0] nxt_value_ff;
  reg nxt_insert_ff;
  reg [7:0] nxt_index_ff;
  reg [1:0] nxt_bank_ff;
  reg nxt_mode_ff;
  reg [1:0] nxt_lane_ff;
  reg nxt_enable_ff;
  reg nxt_commit_ff;
  reg nxt_pready;
  reg nxt_pslverr;
  reg [31:0] nxt_prdata;
  wire [LANES*8-1:0] nxt_pix_out;

  // Address decode and write qualifier
  assign setup = PSEL & ~PENABLE;
  assign hit = (PADDR == `LTHP_CTRL_OFFSET);
  assign wr_go = PSEL & PENABLE & PREADY & PWRITE & hit;

  // Fields of the word being written
  assign wr_value = PWDATA[`LTHP_VALUE_MSB:`LTHP_VALUE_LSB];
  assign wr_insert = PWDATA[`LTHP_INSERT_BIT];
  assign wr_index = PWDATA[`LTHP_INDEX_MSB:`LTHP_INDEX_LSB];
  assign wr_bank = PWDATA[`LTHP_BANK_MSB:`LTHP_BANK_LSB];
  assign wr_mode = PWDATA[`LTHP_MODE_BIT];
  assign wr_lane = PWDATA[`LTHP_LANE_MSB:`LTHP_LANE_LSB];
  assign wr_commit = PWDATA[`LTHP_COMMIT_BIT];
  assign wr_enable = PWDATA[`LTHP_ENABLE_BIT];

  always @* begin
    if (mode_ff | ~enable_ff) begin
      value_view = value_ff;
    end else begin
      value_view = host_rdata;
    end
  end

  // Read word; strobe and reserved bits read zero
  always @* begin
    ctrl_view = 32'h00000000;
    ctrl_view[`LTHP_VALUE_MSB:`LTHP_VALUE_LSB] = value_view;
    ctrl_view[`LTHP_INSERT_BIT] = insert_ff;
    ctrl_view[`LTHP_INDEX_MSB:`LTHP_INDEX_LSB] = index_ff;
    ctrl_view[`LTHP_BANK_MSB:`LTHP_BANK_LSB] = bank_ff;
    ctrl_view[`LTHP_MODE_BIT] = mode_ff;
    ctrl_view[`LTHP_LANE_MSB:`LTHP_LANE_LSB] = lane_ff;
    ctrl_view[`LTHP_ENABLE_BIT] = enable_ff;
  end

  // Table memory; pixel lookup uses the host bank
  lthp_table_mem #(
    .LANES(LANES),
    .BANKS(4),
    .DEPTH(256),
    .DW(8)
  ) u_mem (
    .clk(CLK),
    .host_we(commit_ff),
    .host_bank(bank_ff),
    .host_lane(lane_ff),
    .host_index(index_ff),
    .host_wdata(value_ff),
    .host_rdata(host_rdata),
    .pix_bank(bank_ff),
    .pix_index(PIX_IN),
    .pix_value(pix_value)
  );

  // APB answer: ready one cycle after setup
  always @* begin
    nxt_pready = setup;
    nxt_pslverr = setup & ~hit;
    nxt_prdata = PRDATA;
    // Sampled at setup so data stands in the access phase
    if (setup & ~PWRITE) begin
      nxt_prdata = hit ? ctrl_view : 32'h00000000;
    end
  end

  // Next state of the control register
  always @* begin
    nxt_value_ff = value_ff;
    nxt_insert_ff = insert_ff;
    nxt_index_ff = index_ff;
    nxt_bank_ff = bank_ff;
    nxt_mode_ff = mode_ff;
    nxt_lane_ff = lane_ff;
    nxt_enable_ff = enable_ff;
    nxt_commit_ff = 1'b0;
    if (wr_go) begin
      nxt_index_ff = wr_index;
      nxt_bank_ff = wr_bank;
      nxt_lane_ff = wr_lane;
      nxt_mode_ff = wr_mode;
      nxt_enable_ff = wr_enable;
      nxt_insert_ff = wr_insert;
      // holding register only in mode 1
      if (mode_ff) begin
        nxt_value_ff = wr_value;
      end
      nxt_commit_ff = wr_commit & mode_ff & enable_ff & wr_mode & wr_enable;
    end
  end

  genvar n;
  generate
    for (n = 0; n < LANES; n = n + 1) begin : g_pix
      assign nxt_pix_out[n*8 +: 8] = insert_ff ? pix_value[n*8 +: 8] : PIX_IN[n*8 +: 8];
    end
  endgenerate

  // APB outputs
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h00000000;
    end else begin
      PREADY <= nxt_pready;
      PSLVERR <= nxt_pslverr;
      PRDATA <= nxt_prdata;
    end
  end

  // Control register and commit pulse
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      value_ff <= 8'h00;
      insert_ff <= 1'b0;
      index_ff <= 8'h00;
      bank_ff <= 2'h0;
      mode_ff <= 1'b0;
      lane_ff <= 2'h0;
      enable_ff <= 1'b0;
      commit_ff <= 1'b0;
    end else begin
      value_ff <= nxt_value_ff;
      insert_ff <= nxt_insert_ff;
      index_ff <= nxt_index_ff;
      bank_ff <= nxt_bank_ff;
      mode_ff <= nxt_mode_ff;
      lane_ff <= nxt_lane_ff;
      enable_ff <= nxt_enable_ff;
      commit_ff <= nxt_commit_ff;
    end
  end

  // Pixel outputs one cycle after input
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      PIX_OUT <= {LANES*8{1'b0}};
      PIX_OUT_VALID <= 1'b0;
    end else begin
      PIX_OUT <= nxt_pix_out;
      PIX_OUT_VALID <= PIX_IN_VALID;
    end
  end
endmodule

// ### lthp_map.vh
// Register map, field positions and reset values of the table host port
`ifndef LTHP_MAP_VH
`define LTHP_MAP_VH
`define LTHP_CTRL_OFFSET 12'h000
`define LTHP_VALUE_LSB 0
`define LTHP_VALUE_MSB 7
`define LTHP_INSERT_BIT 15
`define LTHP_INDEX_LSB 16
`define LTHP_INDEX_MSB 23
`define LTHP_BANK_LSB 24
`define LTHP_BANK_MSB 25
`define LTHP_MODE_BIT 27
`define LTHP_LANE_LSB 28
`define LTHP_LANE_MSB 29
`define LTHP_COMMIT_BIT 30
`define LTHP_ENABLE_BIT 31
`define LTHP_CTRL_RESET 32'h00000000
`endif

// ### lthp_table_mem.v
// Banked multi-lane table memory with one host port and per-lane pixel ports
`timescale 1ns/1ps
module lthp_table_mem #(
  parameter LANES = 4,
  parameter BANKS = 4,
  parameter DEPTH = 256,
  parameter DW = 8
) (
  input wire clk, // Clock
  input wire host_we, // Host write pulse
  input wire [1:0] host_bank, // Host bank
  input wire [1:0] host_lane, // Host lane
  input wire [7:0] host_index, // Host location
  input wire [DW-1:0] host_wdata, // Host write data
  output wire [DW-1:0] host_rdata, // Host read data
  input wire [1:0] pix_bank, // Pixel bank
  input wire [LANES*8-1:0] pix_index, // Pixel inputs per lane
  output wire [LANES*DW-1:0] pix_value // Table output per lane
);
  reg [DW-1:0] mem [0:LANES*BANKS*DEPTH-1];
  wire [11:0] host_addr;
  assign host_addr = {host_lane, host_bank, host_index};
  always @(posedge clk) begin
    if (host_we) begin
      mem[host_addr] <= host_wdata;
    end
  end
  assign host_rdata = mem[host_addr];
  genvar g;
  generate
    for (g = 0; g < LANES; g = g + 1) begin : g_lane
      localparam [31:0] LANE_NUM = g;
      wire [1:0] lane_id;
      assign lane_id = LANE_NUM[1:0];
      assign pix_value[g*DW +: DW] = mem[{lane_id, pix_bank, pix_index[g*8 +: 8]}];
    end
  endgenerate
endmodule

// ### lthp_props.sv
// Checker for the table host port
`timescale 1ns/1ps
module lthp_props #(parameter LANES = 4) (input logic CLK, ARST_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR,
  PIX_IN_VALID, PIX_OUT_VALID, input logic [11:0] PADDR, input logic [31:0] PWDATA, PRDATA,
  input logic [LANES*8-1:0] PIX_IN, PIX_OUT);
  default clocking @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  logic ins_ff;
  always_ff @(posedge CLK or negedge ARST_N)
    if (!ARST_N) ins_ff <= 1'b0;
    else if (PREADY && PWRITE && PADDR == 12'h000) ins_ff <= PWDATA[15];
  rdy_after_setup_a:
    assert property (PSEL && !PENABLE |=> PREADY) else $error("no ready");
  rdy_single_a:
    assert property (PREADY |=> !PREADY) else $error("ready held");
  addr_err_a:
    assert property (PREADY |-> PSLVERR == (PADDR != 12'h000)) else $error("error flag");
  err_rdata_a:
    assert property (PREADY && PSLVERR && !PWRITE |-> PRDATA == 32'h0) else $error("error data");
  strobe_reads_a:
    assert property (PREADY && !PWRITE |-> !PRDATA[30]) else $error("strobe reads one");
  rsvd_zero_a:
    assert property (PREADY && !PWRITE |-> PRDATA[14:8] == 7'h00 && !PRDATA[26]) else $error("reserved");
  valid_delay_a:
    assert property (1 |=> PIX_OUT_VALID == $past(PIX_IN_VALID)) else $error("valid delay");
  bypass_path_a:
    assert property (!ins_ff && PIX_IN_VALID |=> PIX_OUT == $past(PIX_IN)) else $error("bypass");
  cover property (PREADY && PWRITE);
  cover property (PREADY && !PWRITE);
  cover property (PREADY && PSLVERR);
endmodule
bind lthp_top lthp_props #(.LANES(LANES)) u_props (.*);

// ### test_lthp_top.sv
// Bench for the table host port
`timescale 1ns/1ps
module test_lthp_top;
  logic CLK = 0, ARST_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, PIX_IN_VALID = 0, er;
  logic [11:0] PADDR = 0;
  logic [31:0] PWDATA = 0, PIX_IN = 0, PRDATA, PIX_OUT, rd;
  logic PREADY, PSLVERR, PIX_OUT_VALID;
  int failures = 0, total_checks = 0, cyc = 0;
  lthp_top dut (.*);
  initial forever #10 CLK = ~CLK;
  task end_of_test;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge CLK) if (++cyc == 20000) begin
    failures++;
    end_of_test;
  end
  task cmp(string n, logic [31:0] e, logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  function logic [31:0] w(logic en, st, md, logic [1:0] ln, bk, logic [7:0] ix, v, logic ins = 0);
    return {en, st, ln, md, 1'b0, bk, ix, ins, 7'h00, v};
  endfunction
  function logic [7:0] tv(logic [1:0] l, b, logic [7:0] i);
    return i ^ {b, l, 4'hA};
  endfunction
  task apb(logic wr, logic [11:0] a, logic [31:0] d);
    PSEL <= 1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK) PENABLE <= 1;
    do @(posedge CLK); while (PREADY !== 1'b1);
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 0;
    PENABLE <= 0;
    @(posedge CLK);
  endtask
  task t_table;
    apb(1, 0, w(1, 0, 1, 0, 0, 0, 0));
    for (int k = 0; k < 32; k++) begin
      apb(1, 0, w(1, 1, 1, k[1:0], k[3:2], {8{k[4]}}, tv(k[1:0], k[3:2], {8{k[4]}})));
    end
    for (int k = 0; k < 32; k++) begin
      apb(1, 0, w(1, 0, 0, k[1:0], k[3:2], {8{k[4]}}, 0));
      apb(0, 0, 0);
      cmp("table", tv(k[1:0], k[3:2], {8{k[4]}}), {24'h0, rd[7:0]});
    end
  endtask
  task t_gate;
    apb(1, 0, w(1, 1, 0, 0, 0, 0, 8'h5A));
    apb(1, 0, w(0, 0, 1, 0, 0, 0, 8'h5A));
    apb(1, 0, w(0, 1, 1, 0, 0, 0, 8'h5A));
    apb(0, 0, 0);
    cmp("held", 32'h0800005A, rd);
    apb(1, 0, w(1, 0, 0, 0, 0, 0, 0));
    apb(0, 0, 0);
    cmp("kept", 32'h8000000A, rd);
  endtask
  task t_pix;
    for (int b = 0; b < 5; b++) begin
      apb(1, 0, w(0, 0, 0, 0, b[1:0], 0, 0, b < 4));
      PIX_IN <= 32'hFF00FF00;
      PIX_IN_VALID <= 1;
      @(posedge CLK);
      @(posedge CLK);
      cmp("pix", b < 4 ? {tv(3, b, 8'hFF), tv(2, b, 0), tv(1, b, 8'hFF), tv(0, b, 0)} : 32'hFF00FF00, PIX_OUT);
      cmp("pixvalid", 1, PIX_OUT_VALID);
      PIX_IN_VALID <= 0;
    end
  endtask
  task t_err;
    apb(1, 12'h004, 32'hFFFFFFFF);
    apb(0, 12'h004, 0);
    cmp("err", 1, er);
    cmp("errdata", 0, rd);
    apb(0, 0, 0);
    cmp("untouched", 0, rd);
  endtask
  initial begin
    repeat (20) @(posedge CLK);
    ARST_N <= 1;
    @(posedge CLK);
    apb(0, 0, 0);
    cmp("reset", 0, rd);
    t_table;
    t_gate;
    t_pix;
    t_err;
    end_of_test;
  end
endmodule
